// ---- rtl/svd_defines.vh ----
// Constants for the supply voltage detect flag block.
// Assumes inclusion by bare name from rtl/.
`ifndef SVD_DEFINES_VH
`define SVD_DEFINES_VH

// Register address width and offsets
`define SVD_ADDR_W           8
`define SVD_OFS_MON          8'h0C
`define SVD_OFS_REQ          8'h0D
`define SVD_OFS_MASK         8'h0E

// Field positions in the monitor register
`define SVD_BIT_ENABLE       0
`define SVD_BIT_LOW          1
`define SVD_BIT_HIGH         2
// Field positions in request and mask registers
`define SVD_BIT_REQ5         5

// Reset values
`define SVD_RST_MON          8'h00
`define SVD_RST_REQ          8'h00
`define SVD_RST_MASK         8'h00

// Timing
`define SVD_CLK_MHZ          50
`define SVD_SETTLE_US        20
`define SVD_SETTLE_CYC       (`SVD_SETTLE_US * `SVD_CLK_MHZ)
`define SVD_CNT_W            10

`endif

// ---- rtl/svd_sync2.v ----
// Two-stage synchroniser for one asynchronous level.
// Assumes the input is a slow level such as a comparator output.
`timescale 1ns/100ps
module svd_sync2
(
  // Clock and reset
  input  wire clock,
  input  wire srst,
  // Level
  input  wire async_in,
  output wire sync_out
);

  reg meta_ff;
  reg sync_ff;

  always @(posedge clock)
  begin
    if (srst)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule // svd_sync2

// ---- rtl/svd_settle.v ----
// Settling counter: valid rises a fixed time after enable rises.
// Assumes enable is a synchronous level in the clock domain.
`timescale 1ns/100ps
`include "svd_defines.vh"
module svd_settle
(
  // Clock and reset
  input  wire clock,
  input  wire srst,
  // Control
  input  wire enable,
  output wire valid
);

  localparam [`SVD_CNT_W-1:0] SETTLE_LAST = `SVD_SETTLE_CYC - 1;

  reg [`SVD_CNT_W-1:0] count_ff;
  reg                  valid_ff;

  always @(posedge clock)
  begin
    if (srst || !enable)
    begin
      count_ff <= {`SVD_CNT_W{1'b0}};
      valid_ff <= 1'b0;
    end
    else if (!valid_ff)
    begin
      if (count_ff == SETTLE_LAST)
        valid_ff <= 1'b1;
      else
        count_ff <= count_ff + 1'b1;
    end
  end

  assign valid = valid_ff;

endmodule // svd_settle

// ---- rtl/svd_top.v ----
// Supply voltage detect flags: control/status, request latch, mask.
// Assumes comparator outputs are asynchronous levels, and a register
// port with read data one cycle after the read strobe.
`timescale 1ns/100ps
`include "svd_defines.vh"
module svd_top
(
  // Clock and reset
  input  wire                   clock,
  input  wire                   srst,
  // Register port
  input  wire [`SVD_ADDR_W-1:0] reg_addr,
  input  wire [7:0]             reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output wire [7:0]             reg_rdata,
  // Comparators and power state
  input  wire                   above_upper_cmp,
  input  wire                   below_lower_cmp,
  input  wire                   stop_mode,
  // Toward the interrupt logic
  output wire                   supply_monitor_enable,
  output wire                   vector_five_request,
  output wire                   vector_five_irq
);

  // ----------------------------------------------------------------
  // Synchronised comparators
  // ----------------------------------------------------------------
  wire high_sync;
  wire low_sync;
  wire settled;

  svd_sync2 u_sync_high
  (
    .clock    (clock),
    .srst     (srst),
    .async_in (above_upper_cmp),
    .sync_out (high_sync)
  );

  svd_sync2 u_sync_low
  (
    .clock    (clock),
    .srst     (srst),
    .async_in (below_lower_cmp),
    .sync_out (low_sync)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg       enable_ff;
  reg       high_flag_ff;
  reg       low_flag_ff;
  reg       req5_ff;
  reg       mask5_ff;
  reg [7:0] rdata_ff;
  reg       irq_ff;

  // Reset image of the monitor register, for bit selection
  localparam [7:0] RST_MON = `SVD_RST_MON;

  wire      mon_active;
  wire      wr_mon;
  wire      wr_req;
  wire      wr_mask;

  assign wr_mon  = reg_wr && (reg_addr == `SVD_OFS_MON);
  assign wr_req  = reg_wr && (reg_addr == `SVD_OFS_REQ);
  assign wr_mask = reg_wr && (reg_addr == `SVD_OFS_MASK);

  // Comparators draw no useful result in stop mode
  assign mon_active = enable_ff && !stop_mode;

  svd_settle u_settle
  (
    .clock  (clock),
    .srst   (srst),
    .enable (mon_active),
    .valid  (settled)
  );

  // Enable bit, only bit 0 of a monitor write is stored
  always @(posedge clock)
  begin
    if (srst)
      enable_ff <= RST_MON[`SVD_BIT_ENABLE];
    else if (wr_mon)
      enable_ff <= reg_wdata[`SVD_BIT_ENABLE];
  end

  // Flags follow the comparators once settled, else read zero
  always @(posedge clock)
  begin
    if (srst)
    begin
      high_flag_ff <= 1'b0;
      low_flag_ff  <= 1'b0;
    end
    else
    begin
      high_flag_ff <= settled && high_sync;
      low_flag_ff  <= settled && low_sync;
    end
  end

  // Sticky request; a new event beats a software clear
  always @(posedge clock)
  begin
    if (srst)
      req5_ff <= 1'b0;
    else if (low_flag_ff && mon_active)
      req5_ff <= 1'b1;
    else if (wr_req && !reg_wdata[`SVD_BIT_REQ5])
      req5_ff <= 1'b0;
  end

  always @(posedge clock)
  begin
    if (srst)
      mask5_ff <= 1'b0;
    else if (wr_mask)
      mask5_ff <= reg_wdata[`SVD_BIT_REQ5];
  end

  always @(posedge clock)
  begin
    if (srst)
      irq_ff <= 1'b0;
    else
      irq_ff <= req5_ff && mask5_ff;
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  reg [7:0] nxt_rdata;

  always @*
  begin
    nxt_rdata = 8'h00;
    case (reg_addr)
      `SVD_OFS_MON:
      begin
        nxt_rdata[`SVD_BIT_ENABLE] = enable_ff;
        nxt_rdata[`SVD_BIT_LOW]    = low_flag_ff;
        nxt_rdata[`SVD_BIT_HIGH]   = high_flag_ff;
      end
      `SVD_OFS_REQ:
        nxt_rdata[`SVD_BIT_REQ5] = req5_ff;
      `SVD_OFS_MASK:
        nxt_rdata[`SVD_BIT_REQ5] = mask5_ff;
      default:
        nxt_rdata = 8'h00;
    endcase
  end

  // Read data stands one cycle, zero otherwise
  always @(posedge clock)
  begin
    if (srst)
      rdata_ff <= 8'h00;
    else if (reg_rd)
      rdata_ff <= nxt_rdata;
    else
      rdata_ff <= 8'h00;
  end

  assign reg_rdata             = rdata_ff;
  assign supply_monitor_enable = enable_ff;
  assign vector_five_request   = req5_ff;
  assign vector_five_irq       = irq_ff;

endmodule // svd_top

// ---- verification/svd_supply_model.sv ----
// Supply comparator model: async levels from a commanded supply state.
// Assumes level 0 normal, 1 above upper, 2 below lower.
`timescale 1ns/100ps
module svd_supply_model
(
  // Command and comparator levels
  input  wire logic [1:0] level,
  output wire logic       above_upper_cmp,
  output wire logic       below_lower_cmp
);
  // Skewed off the clock edge, as a real comparator is unrelated to it
  assign #3 above_upper_cmp = (level == 2'h1);
  assign #3 below_lower_cmp = (level == 2'h2);
endmodule // svd_supply_model

// ---- verification/svd_top_chk.sv ----
// Port checker for svd_top.
// Assumes one clock domain and synchronous srst.
`timescale 1ns/100ps
`include "svd_defines.vh"
module svd_top_chk
(
  // Watched ports
  input wire logic       clock,
  input wire logic       srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       stop_mode,
  input wire logic       supply_monitor_enable,
  input wire logic       vector_five_request,
  input wire logic       vector_five_irq
);
  logic [10:0] cnt_ff;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  always @(posedge clock)
    cnt_ff <= (srst | ~supply_monitor_enable | stop_mode) ? 11'h000
            : cnt_ff + {10'h000, cnt_ff != 11'h7FF};
  chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  chk_en_write: assert property (reg_wr && reg_addr == `SVD_OFS_MON
    |=> supply_monitor_enable == $past(reg_wdata[0])) else $error("enable write lost");
  chk_mon_read: assert property (reg_rd && reg_addr == `SVD_OFS_MON
    |=> reg_rdata[7:3] == 5'h00 && reg_rdata[0] == $past(supply_monitor_enable))
    else $error("monitor read wrong");
  chk_req_settle: assert property ($rose(vector_five_request) |-> cnt_ff >= 11'h3E7)
    else $error("request before settle");
  chk_req_active: assert property ($rose(vector_five_request)
    |-> $past(supply_monitor_enable) && !$past(stop_mode)) else $error("request inactive");
  chk_req_hold: assert property ($fell(vector_five_request) |-> $past(reg_wr))
    else $error("request dropped alone");
  chk_req_read: assert property (reg_rd && reg_addr == `SVD_OFS_REQ
    |=> reg_rdata[5] == $past(vector_five_request)) else $error("request read wrong");
  chk_irq_cause: assert property (vector_five_irq |-> $past(vector_five_request))
    else $error("irq without request");
  cov_req: cover property ($rose(vector_five_request));
  cov_irq: cover property ($rose(vector_five_irq));
  cov_clr: cover property ($fell(vector_five_request));
endmodule // svd_top_chk
bind svd_top svd_top_chk u_chk (.clock, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .stop_mode, .supply_monitor_enable, .vector_five_request, .vector_five_irq);

// ---- verification/svd_top_test.sv ----
// Self-checking bench for svd_top.
// Assumes a 50 MHz clock and the supply comparator model.
`timescale 1ns/100ps
`include "svd_defines.vh"
module svd_top_test;
  logic clock = 0, srst = 1, reg_wr = 0, reg_rd = 0, stop_mode = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [1:0] level = 2'h0;
  wire [7:0] reg_rdata;
  wire above, below, en, req, irq;
  int fail_count = 0, tests_run = 0;
  svd_supply_model u_sup (.level(level), .above_upper_cmp(above), .below_lower_cmp(below));
  svd_top dut (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .above_upper_cmp(above),
    .below_lower_cmp(below), .stop_mode(stop_mode), .supply_monitor_enable(en),
    .vector_five_request(req), .vector_five_irq(irq));
  initial forever #10 clock = ~clock;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin fail_count++; $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp); end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) begin reg_wr <= 1; reg_addr <= a; reg_wdata <= d; end
    @(posedge clock) reg_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock) begin reg_rd <= 1; reg_addr <= a; end
    @(posedge clock) reg_rd <= 0;
    @(negedge clock) d = reg_rdata;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic t_reset;
    logic [7:0] d;
    rd(8'h0C, d); check(d, 8'h00);
    rd(8'h0D, d); check(d, 8'h00);
    rd(8'h0F, d); check(d, 8'h00);
    check({en, req, irq}, 3'h0);
  endtask
  task automatic t_low;
    logic [7:0] d;
    // Stop mode stays off while the low check runs
    level <= 2'h2;
    // Mask stays off here; interrupt path is opened later
    wr(8'h0C, 8'hFF);
    repeat (900) @(posedge clock);
    rd(8'h0C, d); check(d, 8'h01);
    repeat (120) @(posedge clock);
    rd(8'h0C, d); check(d, 8'h03);
    check({req, irq}, 2'h2);
  endtask
  task automatic t_high;
    logic [7:0] d;
    level <= 2'h1;
    repeat (6) @(posedge clock);
    rd(8'h0C, d); check(d, 8'h05);
    rd(8'h0D, d); check(d, 8'h20);
    wr(8'h0E, 8'h20);
    @(posedge clock);
    @(negedge clock) check(irq, 1'b1);
    wr(8'h0D, 8'h00);
    @(posedge clock);
    @(negedge clock) check({req, irq}, 2'h0);
  endtask
  task automatic t_stop;
    logic [7:0] d;
    wr(8'h0C, 8'h00);
    @(posedge clock) begin stop_mode <= 1; level <= 2'h2; end
    repeat (6) @(posedge clock);
    rd(8'h0C, d); check(d, 8'h00);
    check(req, 1'b0);
    wr(8'h0C, 8'h01);
    repeat (1010) @(posedge clock);
    rd(8'h0C, d); check(d, 8'h01);
    check(req, 1'b0);
  endtask
  initial begin
    repeat (4000) @(posedge clock);
    fail_count++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge clock);
    srst <= 0;
    t_reset();
    t_low();
    t_high();
    t_stop();
    give_verdict();
  end
endmodule // svd_top_test
